// [logic/evwc_pkg.sv]
// Shared constants and types of the event and window counter.
package evwc_pkg;

  // ==========================================================================
  // Register byte offsets on the Avalon-MM slave
  // ==========================================================================
  localparam logic [4:0] EVWC_OFF_CONTROL = 5'h00; // Counter control
  localparam logic [4:0] EVWC_OFF_CMP_LOW  = 5'h04; // Compare value, low byte
  localparam logic [4:0] EVWC_OFF_CMP_HIGH = 5'h08; // Compare value, high byte
  localparam logic [4:0] EVWC_OFF_COUNT    = 5'h0c; // Up-counter, read only
  localparam logic [4:0] EVWC_OFF_STATUS   = 5'h10; // Sticky events, W1C
  localparam logic [4:0] EVWC_OFF_MASK     = 5'h14; // Interrupt mask

  // ==========================================================================
  // Field positions of the counter control, status and mask registers
  // ==========================================================================
  localparam int EVWC_RUN_BIT   = 0; // Run bit
  localparam int EVWC_MODE_BIT  = 1; // Operating mode select
  localparam int EVWC_CLK_LSB   = 4; // Source clock select, low bit
  localparam int EVWC_CLK_MSB   = 6; // Source clock select, high bit
  localparam int EVWC_MATCH_BIT = 0; // Match event in status and mask

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int          EVWC_CNT_W     = 16;       // Counter width
  localparam int          EVWC_DIV_W     = 16;       // Prescaler width
  localparam logic [15:0] EVWC_CMP_RESET = 16'hffff; // Compare after reset
  localparam logic [15:0] EVWC_CNT_RESET = 16'h0000; // Counter after reset
  localparam logic [7:0]  EVWC_BYTE_ZERO = 8'h00;    // Cleared byte
  localparam logic [31:0] EVWC_WORD_ZERO = 32'h0000_0000; // Unmapped read

  // ==========================================================================
  // Prescaler exponents per source clock select code (tick every 2^n)
  // ==========================================================================
  localparam logic [3:0] EVWC_EXP_SEL0 = 4'hd; // Slowest rate of the non-reserved codes
  localparam logic [3:0] EVWC_EXP_SEL1 = 4'ha;
  localparam logic [3:0] EVWC_EXP_SEL2 = 4'h8;
  localparam logic [3:0] EVWC_EXP_SEL3 = 4'h3;
  localparam logic [3:0] EVWC_EXP_SEL4 = 4'h0; // Every system clock
  localparam logic [3:0] EVWC_EXP_SEL5 = 4'h9;
  localparam logic [3:0] EVWC_EXP_SEL6 = 4'hf; // Reserved code, slowest
  localparam logic [3:0] EVWC_EXP_SEL7 = 4'hf; // Reserved code, slowest

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [0:0] {
    EVWC_MODE_EVENT  = 1'b0, // Count pin rising edges
    EVWC_MODE_WINDOW = 1'b1  // Count internal ticks while pin is high
  } evwc_mode_type;

endpackage

// [logic/evwc_counter.sv]
// Event and window counter with Avalon-MM register slave and interrupt.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
module evwc_counter
  import evwc_pkg::*;
#(
  parameter int CNT_W = EVWC_CNT_W // Counter and compare width
) (
  input  wire logic        clk_i,               // System clock
  input  wire logic        rst_i,               // Synchronous reset, high
  input  wire logic [4:0]  avs_address_i,       // Byte address
  input  wire logic        avs_read_i,          // Read request
  input  wire logic        avs_write_i,         // Write request
  input  wire logic [3:0]  avs_byteenable_i,    // Byte lanes of a write
  input  wire logic [31:0] avs_writedata_i,     // Write data
  output logic      [31:0] avs_readdata_o,      // Read data
  output logic             avs_waitrequest_o,   // Slave not ready yet
  input  wire logic        counter_input_pin_i, // External event or window
  input  wire logic        stop_mode_i,         // Stop power mode active
  output logic             match_interrupt_o    // Level interrupt
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic             pin_s1;           // First synchroniser stage
  logic             pin_s2;           // Second synchroniser stage
  logic             pin_s3;           // Third synchroniser stage
  logic             pin_level;        // Accepted pin level
  logic             pin_level_d;      // Accepted level, one cycle older
  logic             pin_rise;         // Accepted rising edge
  logic             pin_fall;         // Accepted falling edge
  logic             run_bit;          // Counter running
  evwc_mode_type    operating_mode;   // Event or window
  logic [2:0]       source_clock_select; // Prescaler choice
  logic [CNT_W-1:0] compare_value;    // Value in use for matching
  logic [7:0]       compare_low_hold; // Low byte waiting for high byte
  logic             low_written;      // Low byte written, high pending
  logic [CNT_W-1:0] up_count;         // The up-counter
  logic [CNT_W-1:0] next_up_count;    // Next counter value
  logic             match_event;      // One-cycle match pulse
  logic             status_match;     // Sticky match flag
  logic             mask_match;       // Interrupt enable of match flag
  logic [EVWC_DIV_W-1:0] prescale;    // Free-running divider
  logic [EVWC_DIV_W-1:0] tick_mask;   // Low bits that must all be one
  logic [3:0]       tick_exp;         // Exponent of selected rate
  logic             tick;             // Internal source clock enable
  logic             ack;              // Access completes this cycle
  logic             wr_take;          // Write takes effect this edge
  logic             rd_take;          // Read starts this cycle
  logic             stop_d;           // Stop mode, one cycle older

  // ==========================================================================
  // Pin synchroniser and edge detection
  // ==========================================================================

  // Three stages; the first is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= counter_input_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_level   <= 1'b0;
      pin_level_d <= 1'b0;
    end else begin
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
      pin_level_d <= pin_level;
    end
  end

  // Edges come from accepted levels only, so glitches of one cycle vanish
  assign pin_rise = pin_level & ~pin_level_d;
  assign pin_fall = ~pin_level & pin_level_d;

  // ==========================================================================
  // Internal source clock prescaler
  // ==========================================================================

  // Exponent per select code; reserved codes run at the slowest rate
  always_comb begin
    case (source_clock_select)
      3'h0:    tick_exp = EVWC_EXP_SEL0;
      3'h1:    tick_exp = EVWC_EXP_SEL1;
      3'h2:    tick_exp = EVWC_EXP_SEL2;
      3'h3:    tick_exp = EVWC_EXP_SEL3;
      3'h4:    tick_exp = EVWC_EXP_SEL4;
      3'h5:    tick_exp = EVWC_EXP_SEL5;
      3'h6:    tick_exp = EVWC_EXP_SEL6;
      default: tick_exp = EVWC_EXP_SEL7;
    endcase
  end

  // Mask of low divider bits; a tick fires when they are all ones
  assign tick_mask = EVWC_DIV_W'((32'h0000_0001 << tick_exp) - 32'h0000_0001);
  assign tick      = ((prescale & tick_mask) == tick_mask);

  // Divider runs freely; the first tick after start may come early
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // ==========================================================================
  // Up-counter
  // ==========================================================================

  // Next counter value; a match clears before any increment
  always_comb begin
    next_up_count = up_count;
    match_event   = 1'b0;
    if (run_bit) begin
      if (operating_mode == EVWC_MODE_EVENT) begin
        if (pin_fall && (up_count == compare_value)) begin
          // Match only on the falling edge
          match_event   = 1'b1;
          next_up_count = EVWC_CNT_RESET;
        end else if (pin_rise) begin
          // N rising edges reach N, cleared at the Nth fall
          next_up_count = up_count + 1'b1;
        end
      end else begin
        if (up_count == compare_value) begin
          match_event   = 1'b1;
          next_up_count = EVWC_CNT_RESET;
        end else if (tick && pin_level) begin
          // Internal ticks counted only inside the window
          next_up_count = up_count + 1'b1;
        end
      end
    end
  end

  // Counter holds its value while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_count <= EVWC_CNT_RESET;
    end else begin
      up_count <= next_up_count;
    end
  end

  // ==========================================================================
  // Avalon-MM handshake
  // ==========================================================================

  // One wait state per access; ack marks the completing cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  // Held low when idle so an idle bus never sees a stall
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_take = avs_write_i & ack & avs_byteenable_i[0];
  assign rd_take = avs_read_i & ~ack;

  // Read data captured in the wait cycle, standing in the ack cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= EVWC_WORD_ZERO;
    end else if (rd_take) begin
      avs_readdata_o <= EVWC_WORD_ZERO;
      if (avs_address_i == EVWC_OFF_CONTROL) begin
        avs_readdata_o[EVWC_RUN_BIT]  <= run_bit;
        avs_readdata_o[EVWC_MODE_BIT] <= operating_mode;
        avs_readdata_o[EVWC_CLK_MSB:EVWC_CLK_LSB] <= source_clock_select;
      end else if (avs_address_i == EVWC_OFF_CMP_LOW) begin
        avs_readdata_o[7:0] <= compare_value[7:0];
      end else if (avs_address_i == EVWC_OFF_CMP_HIGH) begin
        avs_readdata_o[7:0] <= compare_value[CNT_W-1:8];
      end else if (avs_address_i == EVWC_OFF_COUNT) begin
        avs_readdata_o[CNT_W-1:0] <= up_count;
      end else if (avs_address_i == EVWC_OFF_STATUS) begin
        avs_readdata_o[EVWC_MATCH_BIT] <= status_match;
      end else if (avs_address_i == EVWC_OFF_MASK) begin
        avs_readdata_o[EVWC_MATCH_BIT] <= mask_match;
      end
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================

  // Stop mode entry clears run and beats a software set in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_d <= 1'b0;
    end else begin
      stop_d <= stop_mode_i;
    end
  end

  // Mode and clock accept writes at any time; software must stop first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_bit             <= 1'b0;
      operating_mode      <= EVWC_MODE_EVENT;
      source_clock_select <= 3'h0;
    end else begin
      if (wr_take && (avs_address_i == EVWC_OFF_CONTROL)) begin
        run_bit        <= avs_writedata_i[EVWC_RUN_BIT];
        operating_mode <= evwc_mode_type'(avs_writedata_i[EVWC_MODE_BIT]);
        source_clock_select <= avs_writedata_i[EVWC_CLK_MSB:EVWC_CLK_LSB];
      end
      if (stop_mode_i && !stop_d) begin
        run_bit <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Compare value, loaded low byte first, then high byte
  // ==========================================================================

  // Old value stays in use until the high byte completes the pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value    <= CNT_W'(EVWC_CMP_RESET);
      compare_low_hold <= EVWC_BYTE_ZERO;
      low_written      <= 1'b0;
    end else if (wr_take) begin
      if (avs_address_i == EVWC_OFF_CMP_LOW) begin
        compare_low_hold <= avs_writedata_i[7:0];
        low_written      <= 1'b1;
      end else if (avs_address_i == EVWC_OFF_CMP_HIGH) begin
        if (low_written) begin
          compare_value <= {avs_writedata_i[CNT_W-9:0], compare_low_hold};
        end
        // A lone high byte is dropped
        low_written <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  // ==========================================================================

  // Sticky flag; a match in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_match <= 1'b0;
    end else if (match_event) begin
      status_match <= 1'b1;
    end else if (wr_take && (avs_address_i == EVWC_OFF_STATUS) &&
                 avs_writedata_i[EVWC_MATCH_BIT]) begin
      status_match <= 1'b0;
    end
  end

  // Mask enables the flag onto the interrupt output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_match <= 1'b0;
    end else if (wr_take && (avs_address_i == EVWC_OFF_MASK)) begin
      mask_match <= avs_writedata_i[EVWC_MATCH_BIT];
    end
  end

  // Level output, high while an enabled flag is set
  assign match_interrupt_o = status_match & mask_match;

endmodule

// [sim/evwc_pulse_source.sv]
// Model of the external event or window pulse source.
module evwc_pulse_source (
  input  wire logic       clk_i,    // System clock
  input  wire logic       start_i,  // Begin a burst of pulses
  input  wire logic [7:0] pulses_i, // Pulses in the burst
  input  wire logic [7:0] high_i,   // High phase, clock cycles
  output logic            pin_o,    // Drives the counter pin
  output logic            busy_o    // Burst in progress
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Burst generator
  // ====================
  int hi; // High phase actually used
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
  end
  // Source drives low between bursts, never floats
  always begin
    @(posedge clk_i);
    if (start_i === 1'b1 && busy_o === 1'b0) begin
      busy_o <= 1'b1;
      hi = (high_i < 8) ? 8 : int'(high_i);
      repeat (pulses_i) begin
        pin_o <= 1'b1;
        repeat (hi) @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (10) @(posedge clk_i); // Low phase of ten
      end
      busy_o <= 1'b0;
    end
  end
endmodule

// [sim/evwc_counter_monitor.sv]
// Port-level checker of the event and window counter.
module evwc_counter_monitor
  import evwc_pkg::*;
#(
  parameter int CNT_W = EVWC_CNT_W // Same width as the design
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        counter_input_pin_i,
  input wire logic        stop_mode_i,
  input wire logic        match_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Helper state
  // ====================
  logic       ev_mode;    // Event mode, as last written
  logic [3:0] since_fall; // Cycles since pin fell, saturates
  logic       done_wr;    // A write completes at this edge
  logic       lane0;      // Lane 0 write completes
  assign done_wr = avs_write_i & ~avs_waitrequest_o;
  assign lane0   = done_wr & avs_byteenable_i[0];
  // Mode follows completed control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_mode <= 1'b1;
    end else if (lane0 && avs_address_i == EVWC_OFF_CONTROL) begin
      ev_mode <= ~avs_writedata_i[EVWC_MODE_BIT];
    end
  end
  // Age of the last pin fall; saturation means long ago
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_fall <= 4'hf;
    end else if ($fell(counter_input_pin_i)) begin
      since_fall <= 4'h0;
    end else if (since_fall != 4'hf) begin
      since_fall <= since_fall + 4'h1;
    end
  end
  // ====================
  // Assertions
  // ====================
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_wait_one_state: assert property (
    $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1
    !avs_waitrequest_o) else $error("bus answer not after one wait");
  chk_idle_no_wait: assert property (
    !avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
    else $error("waitrequest high while idle");
  chk_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o && (avs_address_i[1:0] != 2'h0 ||
    avs_address_i > EVWC_OFF_MASK) |-> avs_readdata_o == EVWC_WORD_ZERO)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (
    $changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data changed without a read");
  chk_irq_sticky: assert property (
    match_interrupt_o && !done_wr |=> match_interrupt_o)
    else $error("interrupt dropped without a write");
  chk_irq_after_fall: assert property (
    ev_mode && $rose(match_interrupt_o) && !$past(done_wr) |->
    since_fall inside {[4'h1:4'h9]})
    else $error("event interrupt not at a pin fall");
  chk_w1c_drops_irq: assert property (
    lane0 && avs_address_i == EVWC_OFF_STATUS && ev_mode &&
    avs_writedata_i[EVWC_MATCH_BIT] && since_fall == 4'hf |=>
    !match_interrupt_o) else $error("status clear kept interrupt");
  chk_mask_drops_irq: assert property (
    lane0 && avs_address_i == EVWC_OFF_MASK &&
    !avs_writedata_i[EVWC_MATCH_BIT] |=> !match_interrupt_o)
    else $error("masked interrupt still high");
endmodule

bind evwc_counter evwc_counter_monitor #(.CNT_W(CNT_W)) u_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .counter_input_pin_i(counter_input_pin_i), .stop_mode_i(stop_mode_i),
  .match_interrupt_o(match_interrupt_o)
);

// [sim/evwc_counter_tb_top.sv]
// Self-checking bench of the event and window counter.
module evwc_counter_tb_top import evwc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;      // System clock
  logic        rst_i;             // Synchronous reset
  logic [4:0]  avs_address_i;     // Bus address
  logic        avs_read_i;        // Bus read
  logic        avs_write_i;       // Bus write
  logic [3:0]  avs_byteenable_i;  // Bus lanes
  logic [31:0] avs_writedata_i;   // Bus write data
  logic [31:0] avs_readdata_o;    // Bus read data
  logic        avs_waitrequest_o; // Bus stall
  logic        stop_mode_i;       // Stop power mode
  logic        match_interrupt_o; // Interrupt level
  logic        pin;               // Counter pin from source
  logic        src_start;         // Burst request
  logic        src_busy;          // Burst running
  logic [7:0]  src_n;             // Pulses per burst
  logic [7:0]  src_h;             // High phase per pulse
  logic [31:0] rd;                // Last read data
  logic [31:0] cnt;               // Expected count
  int          num_errors = 0;    // Mismatches
  int          samples_checked = 0; // Comparisons
  int          n;                 // Event compare value
  int          h;                 // Window pulse length
  int          c;                 // Window compare value
  always #5 clk_i = ~clk_i;
  evwc_counter dut (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .counter_input_pin_i(pin), .stop_mode_i(stop_mode_i),
    .match_interrupt_o(match_interrupt_o));
  evwc_pulse_source u_src (
    .clk_i(clk_i), .start_i(src_start), .pulses_i(src_n), .high_i(src_h),
    .pin_o(pin), .busy_o(src_busy));
  // ====================
  // Expectations and tasks
  // ====================
  // Count left after p pulses with compare m
  function automatic logic [31:0] ev_count(input int p, input int m);
    return 32'(p % m);
  endfunction
  // Compare halves reset to all ones
  function automatic logic [31:0] rst_val(input int i);
    return (i == 1 || i == 2) ? 32'h0000_00ff : 32'h0000_0000;
  endfunction
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Interrupt looked at mid-cycle, once settled
  task automatic irq_is(input logic exp);
    @(negedge clk_i);
    check("interrupt", 32'(exp), 32'(match_interrupt_o));
    @(posedge clk_i);
  endtask
  // One bus cycle; held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    logic busy;
    int   k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge clk_i);
      busy = avs_waitrequest_o;
      rd = avs_readdata_o;
      k++;
    end while (busy !== 1'b0 && k < 50);
    if (k >= 50) num_errors++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Burst of pulses, then time for the pin synchroniser
  task automatic burst(input int p, input int hw);
    int k;
    src_n <= 8'(p);
    src_h <= 8'(hw);
    src_start <= 1'b1;
    @(posedge clk_i);
    src_start <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k < 20000 && src_busy === 1'b1; k++) @(posedge clk_i);
    if (src_busy === 1'b1) num_errors++; // Burst never ended
    repeat (8) @(posedge clk_i);
  endtask
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ====================
  // Scenarios
  // ====================
  initial begin
    rst_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_byteenable_i = 4'hf;
    avs_writedata_i = 32'h0000_0000;
    stop_mode_i = 1'b0;
    src_start = 1'b0;
    src_n = 8'h00;
    src_h = 8'h08;
    n = $urandom(32'h21ee);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Every register, then one unmapped place
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, 5'(4 * i), 32'h0000_0000, 4'hf);
      check("reset value", rst_val(i), rd);
    end
    xfer(1'b1, EVWC_OFF_CMP_HIGH, 32'h0000_0000, 4'hf);
    xfer(1'b0, EVWC_OFF_CMP_HIGH, 32'h0000_0000, 4'hf);
    check("compare high", 32'h0000_00ff, rd);
    n = $urandom_range(6, 3); // Above one
    xfer(1'b1, EVWC_OFF_CMP_LOW, 32'(n), 4'hf);
    xfer(1'b1, EVWC_OFF_CMP_HIGH, 32'h0000_0000, 4'hf);
    xfer(1'b0, EVWC_OFF_CMP_LOW, 32'h0000_0000, 4'hf);
    check("compare low", 32'(n), rd);
    // Lane 0 missing: mask write ignored
    xfer(1'b1, EVWC_OFF_MASK, 32'h0000_0001, 4'he);
    xfer(1'b0, EVWC_OFF_MASK, 32'h0000_0000, 4'hf);
    check("mask", 32'h0000_0000, rd);
    xfer(1'b1, EVWC_OFF_MASK, 32'h0000_0001, 4'hf);
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0041, 4'hf); // Event, run
    burst(n - 1, $urandom_range(12, 8));
    xfer(1'b0, EVWC_OFF_COUNT, 32'h0000_0000, 4'hf);
    check("count", ev_count(n - 1, n), rd);
    irq_is(1'b0);
    burst(1, $urandom_range(12, 8));
    irq_is(1'b1);
    burst(2, 8);
    cnt = ev_count(n + 2, n);
    xfer(1'b0, EVWC_OFF_COUNT, 32'h0000_0000, 4'hf);
    check("count", cnt, rd);
    xfer(1'b1, EVWC_OFF_MASK, 32'h0000_0000, 4'hf);
    irq_is(1'b0);
    xfer(1'b1, EVWC_OFF_MASK, 32'h0000_0001, 4'hf);
    irq_is(1'b1);
    xfer(1'b1, EVWC_OFF_STATUS, 32'h0000_0001, 4'hf);
    irq_is(1'b0);
    // Stopped counter ignores pulses
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0040, 4'hf);
    burst(2, 8);
    xfer(1'b1, EVWC_OFF_COUNT, 32'h0000_1234, 4'hf); // Read only, ignored
    xfer(1'b0, EVWC_OFF_COUNT, 32'h0000_0000, 4'hf);
    check("count", cnt, rd);
    // Entering stop power mode halts a running counter
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0041, 4'hf);
    stop_mode_i <= 1'b1;
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    xfer(1'b0, EVWC_OFF_CONTROL, 32'h0000_0000, 4'hf);
    check("control", 32'h0000_0040, rd);
    burst(1, 8);
    xfer(1'b0, EVWC_OFF_COUNT, 32'h0000_0000, 4'hf);
    check("count", cnt, rd);
    // Window mode, set while stopped; pulses long against tick
    h = $urandom_range(30, 10);
    c = 2 + h + $urandom_range(20, 5);
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0042, 4'hf);
    xfer(1'b1, EVWC_OFF_CMP_LOW, 32'(c), 4'hf);
    xfer(1'b1, EVWC_OFF_CMP_HIGH, 32'h0000_0000, 4'hf);
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0043, 4'hf);
    burst(1, h);
    xfer(1'b0, EVWC_OFF_COUNT, 32'h0000_0000, 4'hf);
    check("count", cnt + 32'(h), rd);
    burst(1, c);
    xfer(1'b0, EVWC_OFF_STATUS, 32'h0000_0000, 4'hf);
    check("status", 32'h0000_0001, rd);
    irq_is(1'b1);
    // Tick every eighth clock: a window of 8*n clocks holds n ticks
    n = $urandom_range(4, 2);
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0042, 4'hf); // Stop first
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0032, 4'hf);
    xfer(1'b1, EVWC_OFF_CONTROL, 32'h0000_0033, 4'hf);
    burst(1, 8 * n);
    xfer(1'b0, EVWC_OFF_COUNT, 32'h0000_0000, 4'hf);
    check("count", 32'(h + 1 + n), rd);
    summarize();
  end
  // Hang guard, far beyond the scenarios' length
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
endmodule
